// [bench/tkm_operator.sv]
// operator model: a finger on the three touch keys
`timescale 1ns/1ps
module tkm_operator (
  input wire logic i_clock,
  output logic o_key_down,
  output logic o_key_up,
  output logic o_key_center
);
  // untouched keys read low from time zero
  initial begin
    o_key_down = 1'b0;
    o_key_up = 1'b0;
    o_key_center = 1'b0;
  end

  // touch {center, up, down} for n cycles, then lift clear of the sensor
  // the long lift lets the synchroniser see a clean release first
  task automatic touch(input logic [2:0] keys, input int n);
    @(negedge i_clock);
    {o_key_center, o_key_up, o_key_down} = keys;
    repeat (n) @(negedge i_clock);
    {o_key_center, o_key_up, o_key_down} = 3'h0;
    repeat (6) @(negedge i_clock);
  endtask : touch
endmodule : tkm_operator

// [bench/touch_key_menu_controller_tb.sv]
// self-checking bench for the touch key menu controller
`timescale 1ns/1ps
module touch_key_menu_controller_tb;
  import tkm_pkg::*;
  localparam logic [2:0] D = 3'h1;
  localparam logic [2:0] U = 3'h2;
  localparam logic [2:0] B = 3'h3;
  localparam logic [2:0] C = 3'h4;
  logic i_clock;
  logic i_rst;
  logic key_down;
  logic key_up;
  logic key_center;
  logic [1:0] switch_state;
  logic value_over;
  logic unit_en;
  logic unit_ph;
  logic [1:0] led;
  logic [2:0] show;
  logic [2:0] item;
  logic [2:0] unit;
  logic blink;
  logic in_base;
  logic ptr_clr;
  logic rescale;
  logic [15:0] low;
  logic [15:0] high;
  logic [15:0] edit;
  logic [1:0] digit;
  logic [7:0] seen;
  logic [1:0] chg;
  logic [1:0] prev_led;
  int clr_cnt;
  int res_cnt;
  int fail_count;
  int comparisons;

  tkm_operator tkm_operator_inst (
    .i_clock(i_clock),
    .o_key_down(key_down),
    .o_key_up(key_up),
    .o_key_center(key_center)
  );

  // long counts shortened so the run stays brief
  localparam longint unsigned T_ENTER = 20;
  localparam longint unsigned T_ABORT = 40;
  localparam longint unsigned T_ESC = 10;
  localparam longint unsigned T_STORE = 20;
  localparam longint unsigned T_IDLE = 100;
  localparam longint unsigned T_BLINK = 4;
  localparam longint unsigned T_FAST = 2;
  localparam longint unsigned T_MARK = 8;
  tkm_menu_ctrl #(
    .ENTER_HOLD(T_ENTER),
    .ENTER_ABORT(T_ABORT),
    .ESC_HOLD(T_ESC),
    .STORE_HOLD(T_STORE),
    .IDLE_LIMIT(T_IDLE),
    .BLINK(T_BLINK),
    .FAST_BLINK(T_FAST),
    .MARKER(T_MARK)
  ) tkm_menu_ctrl_inst (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_key_down(key_down),
    .i_key_up(key_up),
    .i_key_center(key_center),
    .i_switch_state(switch_state),
    .i_value_over(value_over),
    .i_unit_enabled(unit_en),
    .i_unit_phase(unit_ph),
    .o_led(led),
    .o_show(show),
    .o_blink(blink),
    .o_item(item),
    .o_in_base(in_base),
    .o_unit(unit),
    .o_span_low_value(low),
    .o_span_high_value(high),
    .o_edit_value(edit),
    .o_digit(digit),
    .o_pointer_clear(ptr_clr),
    .o_points_rescale(rescale)
  );

  // clock at 20 MHz
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end

  // markers and pulses are short, so latch them between checks
  always @(posedge i_clock) begin
    seen[show] <= 1'b1;
    prev_led <= led;
    if (key_down | key_up | key_center) chg <= chg | (led ^ prev_led);
    if (ptr_clr) clr_cnt <= clr_cnt + 1;
    if (rescale) res_cnt <= res_cnt + 1;
  end

  task automatic check(input string name, input logic [15:0] got,
    input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic cs(input logic [2:0] e);
    check("show", {13'h0, show}, {13'h0, e});
  endtask : cs

  task automatic saw(input logic [2:0] e);
    check("shown", {15'h0, seen[e]}, 16'h0001);
  endtask : saw

  // flash is a slow square wave, so look over one full period
  task automatic blinks(input logic e);
    logic b;
    b = 1'b0;
    repeat (8) begin
      @(negedge i_clock);
      b = b | blink;
    end
    check("blink", {15'h0, b}, {15'h0, e});
  endtask : blinks

  task automatic tap(input logic [2:0] k, input int n);
    seen = '0;
    chg = '0;
    tkm_operator_inst.touch(k, n);
  endtask : tap

  // both arrows past the escape hold, then let the marker run out
  task automatic leave;
    tap(B, 16);
    repeat (10) @(negedge i_clock);
  endtask : leave

  task automatic t_view;
    switch_state = 2'b00;
    tap(D, 12);
    check("led", {14'h0, chg}, 16'h0001);
    cs(SHOW_VALUE);
    tap(C, 12);
    check("led", {14'h0, chg}, 16'h0003);
    saw(SHOW_UNIT);
    cs(SHOW_VALUE);
    switch_state = 2'b10;
    @(negedge i_clock);
    check("led", {14'h0, led}, 16'h0002);
    value_over = 1'b1;
    blinks(1'b1);
    value_over = 1'b0;
    blinks(1'b0);
    unit_ph = 1'b1;
    repeat (2) @(negedge i_clock);
    cs(SHOW_VALUE);
    unit_en = 1'b1;
    repeat (2) @(negedge i_clock);
    cs(SHOW_UNIT);
    unit_ph = 1'b0;
    repeat (2) @(negedge i_clock);
    cs(SHOW_VALUE);
    unit_en = 1'b0;
    $display("test view done");
  endtask : t_view

  task automatic t_nav;
    tap(B, 45);
    cs(SHOW_VALUE);
    tap(B, 25);
    cs(SHOW_MENU);
    check("item", {13'h0, item}, {13'h0, MAIN_BASE});
    tap(U, 4);
    check("item", {13'h0, item}, {13'h0, MAIN_RET});
    tap(D, 12);
    check("item", {13'h0, item}, {13'h0, MAIN_BASE});
    tap(U, 4);
    tap(C, 4);
    cs(SHOW_VALUE);
    tap(B, 25);
    tap(C, 4);
    check("in_base", {15'h0, in_base}, 16'h0001);
    tap(U, 4);
    check("item", {13'h0, item}, {13'h0, BASE_RET});
    tap(C, 4);
    check("in_base", {15'h0, in_base}, 16'h0000);
    tap(C, 4);
    tap(B, 4);
    check("in_base", {15'h0, in_base}, 16'h0000);
    saw(SHOW_GO_UP);
    leave();
    saw(SHOW_ESCAPE);
    cs(SHOW_VALUE);
    tap(B, 25);
    repeat (110) @(negedge i_clock);
    cs(SHOW_VALUE);
    $display("test navigation done");
  endtask : t_nav

  task automatic t_list;
    tap(B, 25);
    tap(C, 4);
    tap(C, 4);
    cs(SHOW_LIST);
    tap(D, 4);
    tap(C, 4);
    saw(SHOW_STORED);
    check("unit", {13'h0, unit}, 16'h0001);
    tap(C, 4);
    tap(D, 4);
    tap(B, 4);
    check("unit", {13'h0, unit}, 16'h0001);
    check("item", {13'h0, item}, {13'h0, BASE_UNIT});
    leave();
    $display("test list done");
  endtask : t_list

  task automatic t_edit;
    int c0;
    int r0;
    tap(B, 25);
    tap(C, 4);
    tap(D, 4);
    tap(D, 4);
    check("item", {13'h0, item}, {13'h0, BASE_HIGH});
    tap(C, 4);
    cs(SHOW_EDIT);
    blinks(1'b1);
    check("digit", {14'h0, digit}, 16'h0000);
    tap(U, 4);
    check("edit", edit, 16'h2000);
    tap(C, 4);
    check("digit", {14'h0, digit}, 16'h0001);
    tap(C, 4);
    tap(C, 4);
    c0 = clr_cnt;
    r0 = res_cnt;
    tap(C, 4);
    saw(SHOW_STORED);
    check("high", high, 16'h2000);
    check("clears", 16'(clr_cnt - c0), 16'h0001);
    check("rescales", 16'(res_cnt - r0), 16'h0001);
    tap(C, 4);
    tap(U, 4);
    tap(B, 4);
    check("high", high, 16'h2000);
    check("item", {13'h0, item}, {13'h0, BASE_HIGH});
    tap(C, 4);
    tap(U, 4);
    tap(C, 25);
    saw(SHOW_STORED);
    check("high", high, 16'h3000);
    tap(C, 4);
    for (int i = 0; i < 3; i++) tap(C, 4);
    tap(D, 4);
    check("edit", edit, 16'h2999);
    tap(B, 4);
    tap(C, 4);
    for (int i = 0; i < 6; i++) tap(U, 4);
    check("edit", edit, 16'h9000);
    tap(U, 4);
    check("edit", edit, 16'h9999);
    tap(D, 4);
    check("edit", edit, 16'h9000);
    tap(B, 4);
    check("high", high, 16'h3000);
    leave();
    $display("test edit done");
  endtask : t_edit

  task automatic t_refuse;
    tap(B, 25);
    tap(C, 4);
    tap(C, 4);
    tap(D, 4);
    tap(D, 4);
    tap(C, 4);
    check("unit", {13'h0, unit}, {13'h0, UNIT_PCT});
    tap(D, 4);
    tap(C, 4);
    cs(SHOW_MENU);
    leave();
    $display("test refuse done");
  endtask : t_refuse

  task automatic end_sim;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim

  // hang guard, far above the length of all tests together
  initial begin
    for (int cyc = 0; cyc < 8000; cyc++) @(posedge i_clock);
    fail_count++;
    $display("Error timeout expected finish seen hang");
    end_sim();
  end

  // main sequence
  initial begin
    i_rst = 1'b1;
    switch_state = 2'b01;
    value_over = 1'b0;
    unit_en = 1'b0;
    unit_ph = 1'b0;
    seen = '0;
    chg = '0;
    clr_cnt = 0;
    res_cnt = 0;
    fail_count = 0;
    comparisons = 0;
    repeat (20) @(negedge i_clock);
    i_rst = 1'b0;
    repeat (5) @(negedge i_clock);
    cs(SHOW_VALUE);
    check("high", high, HIGH_RESET);
    check("low", low, LOW_RESET);
    check("led", {14'h0, led}, 16'h0001);
    $display("test reset done");
    t_view();
    t_nav();
    t_list();
    t_edit();
    t_refuse();
    end_sim();
  end
endmodule : touch_key_menu_controller_tb

// [pkg/tkm_pkg.sv]
// constants and types shared by the touch key menu controller
package tkm_pkg;
  // clock and timing
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned ENTER_HOLD_MS = 2000;
  localparam int unsigned ENTER_ABORT_MS = 4000;
  localparam int unsigned ESC_HOLD_MS = 1000;
  localparam int unsigned STORE_HOLD_MS = 2000;
  localparam int unsigned IDLE_MIN = 5;
  localparam int unsigned BLINK_MS = 250;
  localparam int unsigned FAST_BLINK_MS = 62;
  localparam int unsigned MARKER_MS = 1000;
  localparam longint unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam longint unsigned ENTER_HOLD_CYC = ENTER_HOLD_MS * CYC_PER_MS;
  localparam longint unsigned ENTER_ABORT_CYC = ENTER_ABORT_MS * CYC_PER_MS;
  localparam longint unsigned ESC_HOLD_CYC = ESC_HOLD_MS * CYC_PER_MS;
  localparam longint unsigned STORE_HOLD_CYC = STORE_HOLD_MS * CYC_PER_MS;
  localparam longint unsigned IDLE_CYC = 64'(IDLE_MIN) * 60 * 1000 *
    CYC_PER_MS;
  localparam longint unsigned BLINK_CYC = BLINK_MS * CYC_PER_MS;
  localparam longint unsigned FAST_BLINK_CYC = FAST_BLINK_MS * CYC_PER_MS;
  localparam longint unsigned MARKER_CYC = MARKER_MS * CYC_PER_MS;
  // menu geometry
  localparam int unsigned MAIN_ITEMS = 6;
  localparam int unsigned BASE_ITEMS = 7;
  localparam logic [2:0] MAIN_BASE = 3'h0;
  localparam logic [2:0] MAIN_RET = 3'h5;
  localparam logic [2:0] BASE_UNIT = 3'h0;
  localparam logic [2:0] BASE_LOW = 3'h1;
  localparam logic [2:0] BASE_HIGH = 3'h2;
  localparam logic [2:0] BASE_DAMP = 3'h3;
  localparam logic [2:0] BASE_MIN = 3'h4;
  localparam logic [2:0] BASE_MAX = 3'h5;
  localparam logic [2:0] BASE_RET = 3'h6;
  // units
  localparam int unsigned UNIT_COUNT = 5;
  localparam logic [2:0] UNIT_PCT = 3'h3;
  localparam logic [2:0] UNIT_MA = 3'h4;
  // reset values and digit count
  localparam logic [15:0] LOW_RESET = 16'h0000;
  localparam logic [15:0] HIGH_RESET = 16'h1000;
  localparam logic [2:0] UNIT_RESET = 3'h0;
  localparam int unsigned DIGITS = 4;
  // display content and controller states
  typedef enum logic [2:0] {
    SHOW_VALUE = 3'b000,
    SHOW_UNIT = 3'b001,
    SHOW_MENU = 3'b010,
    SHOW_EDIT = 3'b011,
    SHOW_GO_UP = 3'b100,
    SHOW_ESCAPE = 3'b101,
    SHOW_STORED = 3'b110,
    SHOW_LIST = 3'b111
  } show_e;
  typedef enum logic [2:0] {
    ST_VIEW = 3'b000,
    ST_ENTER = 3'b001,
    ST_MENU = 3'b010,
    ST_LIST = 3'b011,
    ST_EDIT = 3'b100,
    ST_HOLD_BOTH = 3'b101,
    ST_WAIT_REL = 3'b110
  } state_e;
endpackage : tkm_pkg

// [rtl/tkm_key_sync.sv]
// key synchroniser with rising-edge event detection
`timescale 1ns/1ps
module tkm_key_sync
  import tkm_pkg::*;
#(
  parameter int unsigned WIDTH = 3
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_raw,
  output logic [WIDTH-1:0] o_level,
  output logic [WIDTH-1:0] o_rise
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] prev;
  } sync_s;
  sync_s r;
  sync_s next_r;

  initial begin
    if (WIDTH < 1) $error("key width must be at least one");
  end

  // meta is read only by sync; edges come from the second stage onward
  always_comb begin
    next_r = r;
    next_r.meta = i_raw;
    next_r.sync = r.meta;
    next_r.prev = r.sync;
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign o_level = r.sync;
  assign o_rise = r.sync & ~r.prev; // one event per touch
endmodule : tkm_key_sync

// [rtl/tkm_menu_ctrl.sv]
// touch key menu controller: modes, menus, lists, digit entry, leds
`timescale 1ns/1ps
// What this block does
// [RL1] touch flashes leds per key, outputs untouched
// [RL2] untouched leds mirror switching outputs
// [RL3] power-up enters display mode showing value
// [RL4] flash value when above presentable maximum
// [RL5] center shows unit; lone arrow ignored
// [RL6] both arrows 2 s enters configuration
// [RL7] still held at 4 s returns display
// [RL8] arrows move items, center selects/exits
// [RL9] return item goes up; main returns display
// [RL10] menu navigation wraps both ways
// [RL11] both arrows go up, flash return marker
// [RL12] both held over 1 s escapes display
// [RL13] five minutes idle returns display mode
// [RL14] list: arrows step, center stores, both cancel
// [RL15] digit flashes, up/down change with carry
// [RL16] over-limit shows limit; either arrow restores
// [RL17] center advances digit; both cancels entry
// [RL18] last digit center commits and stores
// [RL19] center hold 2 s stores partial value
// [RL20] range change clears min and max pointers
// [RL21] switch points kept as range percentage
// [RL22] range low 4 mA; span; not %/mA
// [RL23] each touch acts once on rising edge
module tkm_menu_ctrl
  import tkm_pkg::*;
#(
  parameter longint unsigned ENTER_HOLD = ENTER_HOLD_CYC,
  parameter longint unsigned ENTER_ABORT = ENTER_ABORT_CYC,
  parameter longint unsigned ESC_HOLD = ESC_HOLD_CYC,
  parameter longint unsigned STORE_HOLD = STORE_HOLD_CYC,
  parameter longint unsigned IDLE_LIMIT = IDLE_CYC,
  parameter longint unsigned BLINK = BLINK_CYC,
  parameter longint unsigned FAST_BLINK = FAST_BLINK_CYC,
  parameter longint unsigned MARKER = MARKER_CYC,
  parameter logic [15:0] RANGE_MIN = 16'h0000,
  parameter logic [15:0] RANGE_MAX = 16'h9999,
  parameter logic [15:0] MIN_SPAN = 16'h1000
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_key_down,
  input wire logic i_key_up,
  input wire logic i_key_center,
  input wire logic [1:0] i_switch_state,
  input wire logic i_value_over,
  input wire logic i_unit_enabled,
  input wire logic i_unit_phase,
  output logic [1:0] o_led,
  output logic [2:0] o_show,
  output logic o_blink,
  output logic [2:0] o_item,
  output logic o_in_base,
  output logic [2:0] o_unit,
  output logic [15:0] o_span_low_value,
  output logic [15:0] o_span_high_value,
  output logic [15:0] o_edit_value,
  output logic [1:0] o_digit,
  output logic o_pointer_clear,
  output logic o_points_rescale
);
  localparam int CW = 34;

  typedef struct packed {
    state_e st;
    show_e show;
    logic in_base;
    logic [2:0] item;
    logic [2:0] list_sel;
    logic [2:0] unit;
    logic [15:0] low;
    logic [15:0] high;
    logic [15:0] edit;
    logic [15:0] undo;
    logic limited;
    logic [1:0] digit;
    logic [CW-1:0] hold;
    logic [CW-1:0] idle;
    logic [CW-1:0] mark;
    logic [CW-1:0] blink_cnt;
    logic [CW-1:0] fast_cnt;
    logic slow_ph;
    logic fast_ph;
    logic ptr_clr;
    logic rescale;
    logic from_val; // both arrows came from a list or an entry
  } ctrl_s;
  ctrl_s r;
  ctrl_s next_r;

  logic [2:0] lvl;
  logic [2:0] rise;
  logic both;
  logic any_key;

  initial begin
    if (ENTER_ABORT <= ENTER_HOLD) $error("abort time must exceed entry");
    if (ESC_HOLD < 1 || BLINK < 1 || FAST_BLINK < 1) $error("bad count");
    if (IDLE_LIMIT >= (64'h1 << CW)) $error("idle count too wide");
  end

  tkm_key_sync #(
    .WIDTH(3)
  ) tkm_key_sync_inst (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_raw({i_key_center, i_key_up, i_key_down}),
    .o_level(lvl),
    .o_rise(rise)
  );

  assign both = lvl[0] & lvl[1];
  assign any_key = |lvl;

  // bcd digit step with carry/borrow into higher digits
  function automatic logic [15:0] bcd_step(input logic [15:0] v,
                                           input logic [1:0] pos,
                                           input logic up);
    logic [15:0] res;
    logic go;
    res = v;
    go = 1'b1;
    for (int i = 0; i < DIGITS; i++) begin
      if (go && i >= 3 - int'(pos)) begin
        if (up) begin
          go = (res[i*4 +: 4] == 4'h9);
          res[i*4 +: 4] = go ? 4'h0 : res[i*4 +: 4] + 4'h1;
        end else begin
          go = (res[i*4 +: 4] == 4'h0);
          res[i*4 +: 4] = go ? 4'h9 : res[i*4 +: 4] - 4'h1;
        end
      end
    end
    return res;
  endfunction : bcd_step

  // wrapped menu step
  function automatic logic [2:0] wrap(input logic [2:0] v,
                                      input logic [2:0] n,
                                      input logic up);
    if (up) begin
      return (v == 3'h0) ? n - 3'h1 : v - 3'h1;
    end
    return (v == n - 3'h1) ? 3'h0 : v + 3'h1;
  endfunction : wrap

  // main next-state logic
  always_comb begin
    logic [2:0] n_items;
    logic [15:0] cand;
    logic [15:0] lo_lim;
    logic [15:0] hi_lim;
    n_items = 3'h0;
    cand = 16'h0000;
    lo_lim = RANGE_MIN;
    hi_lim = RANGE_MAX;
    next_r = r;
    next_r.ptr_clr = 1'b0;
    next_r.rescale = 1'b0;
    // blink phase generators
    next_r.blink_cnt = r.blink_cnt + CW'(1);
    if (r.blink_cnt >= CW'(BLINK - 1)) begin
      next_r.blink_cnt = '0;
      next_r.slow_ph = ~r.slow_ph;
    end
    next_r.fast_cnt = r.fast_cnt + CW'(1);
    if (r.fast_cnt >= CW'(FAST_BLINK - 1)) begin
      next_r.fast_cnt = '0;
      next_r.fast_ph = ~r.fast_ph;
    end
    // hold counter runs while any key is held
    next_r.hold = any_key ? r.hold + CW'(1) : '0;
    if (any_key || r.st == ST_VIEW) next_r.idle = '0;
    else next_r.idle = r.idle + CW'(1);
    if (r.mark != '0) next_r.mark = r.mark - CW'(1);
    n_items = r.in_base ? 3'(BASE_ITEMS) : 3'(MAIN_ITEMS);
    // edit limits; a span of at least MIN_SPAN is kept
    if (r.item == BASE_LOW) hi_lim = r.high - MIN_SPAN; // RL22
    else lo_lim = r.low + MIN_SPAN; // RL22
    case (r.st)
      ST_VIEW: begin
        next_r.show = (lvl[2] || (i_unit_enabled && i_unit_phase)) ?
          SHOW_UNIT : SHOW_VALUE; // RL5 RL3
        if (r.mark != '0) next_r.show = r.show;
        if (both && rise[1:0] != 2'b00) begin
          next_r.st = ST_ENTER; // RL6
          next_r.hold = '0;
        end
      end
      ST_ENTER: begin
        if (!both) begin
          next_r.st = (r.hold >= CW'(ENTER_HOLD)) ? ST_MENU : ST_VIEW; // RL6
          next_r.in_base = 1'b0;
          next_r.item = MAIN_BASE;
          next_r.show = (r.hold >= CW'(ENTER_HOLD)) ? SHOW_MENU : SHOW_VALUE;
        end else if (r.hold >= CW'(ENTER_ABORT)) begin
          next_r.st = ST_WAIT_REL; // RL7
          next_r.show = SHOW_VALUE;
        end else if (r.hold >= CW'(ENTER_HOLD)) begin
          next_r.show = SHOW_MENU;
        end
      end
      ST_WAIT_REL: begin
        if (!any_key) next_r.st = ST_VIEW;
      end
      ST_MENU: begin
        if (r.mark == '0) next_r.show = SHOW_MENU;
        if (both) begin
          next_r.st = ST_HOLD_BOTH; // RL11
          next_r.from_val = 1'b0;
          next_r.show = SHOW_GO_UP;
          next_r.hold = '0;
        end else if (rise[0] || rise[1]) begin
          next_r.item = wrap(r.item, n_items, rise[1]); // RL8 RL10 RL23
          next_r.show = SHOW_MENU;
        end else if (rise[2]) begin
          if (!r.in_base) begin
            if (r.item == MAIN_RET) begin
              next_r.st = ST_VIEW; // RL9
              next_r.show = SHOW_VALUE;
            end else if (r.item == MAIN_BASE) begin
              next_r.in_base = 1'b1; // RL8
              next_r.item = BASE_UNIT;
            end
          end else begin
            case (r.item)
              BASE_RET: begin
                next_r.in_base = 1'b0; // RL9
                next_r.item = MAIN_BASE;
              end
              BASE_UNIT: begin
                next_r.st = ST_LIST;
                next_r.list_sel = r.unit;
                next_r.show = SHOW_LIST;
              end
              BASE_LOW, BASE_HIGH: begin
                if (r.unit != UNIT_PCT && r.unit != UNIT_MA) begin
                  next_r.st = ST_EDIT; // RL22
                  next_r.edit = (r.item == BASE_LOW) ? r.low : r.high;
                  next_r.undo = next_r.edit;
                  next_r.digit = 2'h0;
                  next_r.limited = 1'b0;
                  next_r.show = SHOW_EDIT;
                end
              end
              default: begin
                next_r.show = SHOW_MENU; // value item: stays at its item
              end
            endcase
          end
        end
        if (r.idle >= CW'(IDLE_LIMIT)) begin
          next_r.st = ST_VIEW; // RL13
          next_r.show = SHOW_VALUE;
        end
      end
      ST_HOLD_BOTH: begin
        if (!both) begin
          next_r.st = ST_MENU; // RL11
          next_r.mark = CW'(MARKER);
          if (r.from_val) begin
            next_r.in_base = r.in_base; // RL14 RL17 back to its own item
          end else if (r.in_base) begin
            next_r.in_base = 1'b0;
            next_r.item = MAIN_BASE;
          end else begin
            next_r.st = ST_VIEW;
            next_r.show = SHOW_VALUE;
          end
        end else if (r.hold > CW'(ESC_HOLD)) begin
          next_r.st = ST_WAIT_REL; // RL12
          next_r.show = SHOW_ESCAPE;
          next_r.mark = CW'(MARKER);
        end
      end
      ST_LIST: begin
        if (both) begin
          next_r.st = ST_HOLD_BOTH; // RL14
          next_r.from_val = 1'b1;
          next_r.show = SHOW_GO_UP;
          next_r.hold = '0;
        end else if (rise[0] || rise[1]) begin
          next_r.list_sel = wrap(r.list_sel, 3'(UNIT_COUNT), rise[1]); // RL14
        end else if (rise[2]) begin
          next_r.unit = r.list_sel; // RL14
          next_r.st = ST_MENU;
          next_r.show = SHOW_STORED;
          next_r.mark = CW'(MARKER);
        end
        if (r.idle >= CW'(IDLE_LIMIT)) begin
          next_r.st = ST_VIEW; // RL13
          next_r.show = SHOW_VALUE;
        end
      end
      ST_EDIT: begin
        if (both) begin
          next_r.st = ST_HOLD_BOTH; // RL17
          next_r.from_val = 1'b1;
          next_r.show = SHOW_GO_UP;
          next_r.hold = '0;
        end else if (rise[0] || rise[1]) begin
          if (r.limited) begin
            next_r.edit = r.undo; // RL16
            next_r.limited = 1'b0;
          end else begin
            cand = bcd_step(r.edit, r.digit, rise[1]); // RL15
            next_r.undo = r.edit;
            if (cand > hi_lim || cand < lo_lim ||
                (rise[1] && cand < r.edit) ||
                (rise[0] && cand > r.edit)) begin
              next_r.edit = rise[1] ? hi_lim : lo_lim; // RL16
              next_r.limited = 1'b1;
            end else begin
              next_r.edit = cand;
            end
          end
        end else if ((rise[2] && r.digit == 2'h3) ||
                     (lvl[2] && r.hold == CW'(STORE_HOLD))) begin
          next_r.st = ST_MENU; // RL18 RL19
          next_r.show = SHOW_STORED;
          next_r.mark = CW'(MARKER);
          if (r.item == BASE_LOW) next_r.low = r.edit;
          else next_r.high = r.edit;
          next_r.ptr_clr = 1'b1; // RL20
          next_r.rescale = 1'b1; // RL21
        end else if (rise[2]) begin
          next_r.digit = r.digit + 2'h1; // RL17
          next_r.limited = 1'b0;
        end
        if (r.idle >= CW'(IDLE_LIMIT)) begin
          next_r.st = ST_VIEW; // RL13
          next_r.show = SHOW_VALUE;
        end
      end
      default: begin
        next_r.st = ST_VIEW;
      end
    endcase
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      r <= '0; // RL3
      r.st <= ST_VIEW;
      r.show <= SHOW_VALUE;
      r.unit <= UNIT_RESET;
      r.low <= LOW_RESET;
      r.high <= HIGH_RESET;
    end else begin
      r <= next_r;
    end
  end

  // led feedback over switch state; outputs themselves never touched
  always_comb begin
    if (lvl[2]) o_led = {2{r.fast_ph}}; // RL1
    else if (lvl[1:0] != 2'b00) o_led = {lvl[1], lvl[0]} & {2{r.slow_ph}};
    else o_led = i_switch_state; // RL2
  end

  assign o_show = r.show;
  assign o_blink = r.slow_ph & ((r.st == ST_VIEW && i_value_over) || // RL4
    r.st == ST_EDIT || r.show == SHOW_GO_UP || r.show == SHOW_ESCAPE);
  assign o_item = r.item;
  assign o_in_base = r.in_base;
  assign o_unit = r.unit;
  assign o_span_low_value = r.low;
  assign o_span_high_value = r.high;
  assign o_edit_value = r.edit;
  assign o_digit = r.digit;
  assign o_pointer_clear = r.ptr_clr;
  assign o_points_rescale = r.rescale;

  // last item of the menu in use
  function automatic logic [2:0] n_last();
    return r.in_base ? 3'(BASE_ITEMS - 1) : 3'(MAIN_ITEMS - 1);
  endfunction : n_last

  // checks
  wrap_ok_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (r.st == ST_MENU && rise[0] && !lvl[1] && r.item == n_last())
    |=> r.item == 3'h0) else $error("menu did not wrap"); // RL10
  led_idle_a: assert property (@(posedge i_clock) disable iff (i_rst)
    !any_key |-> o_led == i_switch_state)
    else $error("leds not mirroring switches"); // RL2
  unit_show_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (r.st == ST_VIEW && lvl[2] && r.mark == '0) |=> r.show == SHOW_UNIT)
    else $error("unit not shown"); // RL5
  store_clr_a: assert property (@(posedge i_clock) disable iff (i_rst)
    $rose(r.ptr_clr) |-> r.show == SHOW_STORED && r.st == ST_MENU)
    else $error("pointer clear without store"); // RL20
  list_store_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (r.st == ST_LIST && rise[2] && !both && rise[1:0] == 2'b00 &&
     r.idle < CW'(IDLE_LIMIT))
    |=> r.unit == $past(r.list_sel) && r.st == ST_MENU)
    else $error("list choice not stored"); // RL14
  idle_out_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (r.st == ST_MENU && r.idle >= CW'(IDLE_LIMIT)) |=> r.st == ST_VIEW)
    else $error("idle timeout missed"); // RL13
  escape_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (r.st == ST_HOLD_BOTH && both && r.hold > CW'(ESC_HOLD))
    |=> r.show == SHOW_ESCAPE ##1 (r.st != ST_MENU))
    else $error("escape missed"); // RL12
  range_lock_a: assert property (@(posedge i_clock) disable iff (i_rst)
    $rose(r.st == ST_EDIT) |-> r.unit != UNIT_PCT && r.unit != UNIT_MA)
    else $error("range edit in percent or mA"); // RL22
  cover_enter_c: cover property (@(posedge i_clock) disable iff (i_rst)
    r.st == ST_ENTER ##1 r.st == ST_MENU);
  cover_store_c: cover property (@(posedge i_clock) disable iff (i_rst)
    r.st == ST_EDIT ##1 r.show == SHOW_STORED);
  cover_limit_c: cover property (@(posedge i_clock) disable iff (i_rst)
    $rose(r.limited));
endmodule : tkm_menu_ctrl
